// file: rtl/pfta_pkg.sv
// package for the program flash table access block
// assumes one 100 MHz clock and an ideal word-wide flash array model inside the top
package pfta_pkg;
  localparam int ADDR_W = 12;
  localparam int HOLD_BYTES = 64;
  localparam int HOLD_W = 6;
  localparam int PAIR_BYTES = 2;
  localparam int ERASE_BYTES = 1024;
  localparam int ERASE_W = 10;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 2;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_TIME_US = 20;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    PFTA_CMD_NONE = 3'h0,
    PFTA_CMD_READ = 3'h1,
    PFTA_CMD_WRITE = 3'h2,
    PFTA_CMD_PROG_BLK = 3'h3,
    PFTA_CMD_PROG_PAIR = 3'h4,
    PFTA_CMD_ERASE = 3'h5,
    PFTA_CMD_BULK = 3'h6
  } pfta_cmd_t;
  typedef enum logic [1:0] {
    PFTA_IDLE = 2'b00,
    PFTA_BUSY = 2'b01,
    PFTA_DONE = 2'b11
  } pfta_state_t;
endpackage

// file: rtl/pfta_buf_if.sv
// carrier between the table-read path and the two-entry latch buffer
// assumes single clock domain
`timescale 1ns/1ps
`default_nettype none
interface pfta_buf_if;
  logic in_valid;
  logic in_ready;
  logic [7:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  modport src (output in_valid, output in_data, input in_ready,
    input out_valid, input out_data, output out_ready);
  modport buf_side (input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// file: rtl/pfta_skid.sv
// two-entry buffer on the table latch data path
// assumes producer and consumer share core_clk_i
`timescale 1ns/1ps
`default_nettype none
module pfta_skid #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // stream
  pfta_buf_if.buf_side bus
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = bus.in_valid && bus.in_ready;
  wire pop = bus.out_valid && bus.out_ready;
  assign bus.in_ready = (count != 2'(DEPTH));
  assign bus.out_valid = (count != 2'h0);
  assign bus.out_data = mem[rd_ptr];
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + 2'(push) - 2'(pop);
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (push) mem[wr_ptr] <= bus.in_data;
  end
endmodule
`default_nettype wire

// file: rtl/pfta_top.sv
// table read/write and self-programming sequencer with a small flash array
// assumes the core issues one command per cycle and honours busy_o
`timescale 1ns/1ps
`default_nettype none
module pfta_top #(
  parameter int PROG_CYC = pfta_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = pfta_pkg::ERASE_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command from the core
  input wire logic cmd_valid_i,
  input wire logic [2:0] cmd_i,
  input wire logic [pfta_pkg::ADDR_W-1:0] tbl_addr_i,
  input wire logic [7:0] wr_byte_i,
  // table latch output toward data ram
  output logic rd_valid_o,
  output logic [7:0] rd_byte_o,
  input wire logic rd_ready_i,
  // instruction fetch
  input wire logic [pfta_pkg::ADDR_W-2:0] fetch_addr_i,
  output logic [15:0] fetch_word_o,
  // status
  output logic busy_o,
  output logic refused_o,
  output logic done_o
);
  localparam int WORDS = (1 << pfta_pkg::ADDR_W) / 2;
  localparam int AW = pfta_pkg::ADDR_W;
  logic [15:0] flash [WORDS];
  logic [7:0] hold [pfta_pkg::HOLD_BYTES];
  logic [7:0] table_latch;
  logic lat_valid;
  pfta_pkg::pfta_state_t state, next_state;
  logic [15:0] timer;
  logic [2:0] op;
  logic [AW-1:0] op_addr;
  pfta_buf_if bif ();

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction
  function automatic logic opcode_ok(input logic [15:0] w);
    opcode_ok = (w != pfta_pkg::ERASED_WORD);
  endfunction

  wire idle = (state == pfta_pkg::PFTA_IDLE);
  wire [2:0] cmd = cmd_i;
  wire take = cmd_valid_i && idle;
  wire is_rd = take && (cmd == pfta_pkg::PFTA_CMD_READ) && !lat_valid;
  wire is_wr = take && (cmd == pfta_pkg::PFTA_CMD_WRITE);
  wire is_commit = take && (cmd == pfta_pkg::PFTA_CMD_PROG_BLK ||
    cmd == pfta_pkg::PFTA_CMD_PROG_PAIR || cmd == pfta_pkg::PFTA_CMD_ERASE);
  wire is_bulk = cmd_valid_i && (cmd == pfta_pkg::PFTA_CMD_BULK);
  wire [15:0] rd_word = flash[tbl_addr_i[AW-1:1]];
  wire [15:0] fetch_raw = flash[fetch_addr_i];
  // an erased word decodes as nothing, so the core sees a no-op
  wire [15:0] next_fetch = opcode_ok(fetch_raw) ? fetch_raw : pfta_pkg::NOP_WORD;
  // fetch output frozen through busy and the expiry edge
  wire fetch_upd = (next_state == pfta_pkg::PFTA_IDLE) && (state != pfta_pkg::PFTA_BUSY);
  wire [15:0] limit = (op == pfta_pkg::PFTA_CMD_ERASE) ? 16'(ERASE_CYC) : 16'(PROG_CYC);
  wire expire = (state == pfta_pkg::PFTA_BUSY) && (timer == limit - 16'h1);

  always_comb begin
    next_state = state;
    case (state)
      pfta_pkg::PFTA_IDLE: if (is_commit) next_state = pfta_pkg::PFTA_BUSY;
      pfta_pkg::PFTA_BUSY: if (expire) next_state = pfta_pkg::PFTA_DONE;
      pfta_pkg::PFTA_DONE: next_state = pfta_pkg::PFTA_IDLE;
      default: next_state = pfta_pkg::PFTA_IDLE;
    endcase
  end

  // table latch is the only byte path from flash to data ram; writes reach hold straight from wr_byte_i
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      table_latch <= 8'h00;
      lat_valid <= 1'b0;
    end else begin
      if (is_rd) begin
        table_latch <= pick_byte(rd_word, tbl_addr_i[0]);
        lat_valid <= 1'b1;
      end else if (lat_valid && bif.in_ready) begin
        lat_valid <= 1'b0;
      end
      if (is_wr) table_latch <= wr_byte_i;
    end
  end

  // a full buffer holds the latch until it drains; a table write meanwhile replaces the held byte
  assign bif.in_valid = lat_valid;
  assign bif.in_data = table_latch;
  assign bif.out_ready = rd_ready_i || !rd_valid_o;
  pfta_skid #(.WIDTH(8), .DEPTH(2)) u_buf (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(bif)
  );

  always_ff @(posedge core_clk_i) begin
    if (is_wr) hold[tbl_addr_i[pfta_pkg::HOLD_W-1:0]] <= wr_byte_i;
  end

  // commit happens at timer expiry so flash changes only at the end
  always_ff @(posedge core_clk_i) begin
    if (expire) begin
      if (op == pfta_pkg::PFTA_CMD_ERASE) begin
        for (int i = 0; i < WORDS; i++)
          if ((i >> (pfta_pkg::ERASE_W - 1)) == int'(op_addr >> pfta_pkg::ERASE_W))
            flash[i] <= pfta_pkg::ERASED_WORD;
      end else if (op == pfta_pkg::PFTA_CMD_PROG_BLK) begin
        for (int j = 0; j < pfta_pkg::HOLD_BYTES / 2; j++)
          flash[{op_addr[AW-1:pfta_pkg::HOLD_W], 5'(j)}] <=
            {hold[2*j+1], hold[2*j]};
      end else begin
        flash[op_addr[AW-1:1]] <= {hold[{op_addr[pfta_pkg::HOLD_W-1:1], 1'b1}],
          hold[{op_addr[pfta_pkg::HOLD_W-1:1], 1'b0}]};
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= pfta_pkg::PFTA_IDLE;
      timer <= 16'h0000;
      op <= 3'h0;
      op_addr <= '0;
      busy_o <= 1'b0;
      refused_o <= 1'b0;
      done_o <= 1'b0;
      fetch_word_o <= 16'h0000;
      rd_valid_o <= 1'b0;
      rd_byte_o <= 8'h00;
    end else begin
      state <= next_state;
      timer <= (state == pfta_pkg::PFTA_BUSY) ? timer + 16'h1 : 16'h0000;
      if (is_commit) begin
        op <= cmd;
        op_addr <= tbl_addr_i;
      end
      busy_o <= (next_state == pfta_pkg::PFTA_BUSY);
      refused_o <= is_bulk;
      done_o <= expire;
      if (fetch_upd)
        fetch_word_o <= next_fetch;
      if (bif.out_ready) begin
        rd_valid_o <= bif.out_valid;
        rd_byte_o <= bif.out_data;
      end
    end
  end

  property p_busy_len;
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(busy_o) |-> busy_o [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy ended early");

  property p_done_after;
    @(posedge core_clk_i) disable iff (rst_i)
      done_o |-> $past(busy_o) && !busy_o;
  endproperty
  a_done_after: assert property (p_done_after) else $error("done without busy");

  property p_bulk_refused;
    @(posedge core_clk_i) disable iff (rst_i)
      (is_bulk && idle) |=> refused_o && !busy_o;
  endproperty
  a_bulk_refused: assert property (p_bulk_refused) else $error("bulk erase ran");

  property p_fetch_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      busy_o |=> $stable(fetch_word_o);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved while busy");

  property p_no_rd_busy;
    @(posedge core_clk_i) disable iff (rst_i)
      busy_o |-> !is_rd && !is_wr;
  endproperty
  a_no_rd_busy: assert property (p_no_rd_busy) else $error("access while busy");

  property p_read_latch;
    @(posedge core_clk_i) disable iff (rst_i)
      is_rd |=> lat_valid && table_latch == pick_byte($past(rd_word), $past(tbl_addr_i[0]));
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("wrong byte latched");

  property p_write_latch;
    @(posedge core_clk_i) disable iff (rst_i)
      is_wr |=> table_latch == $past(wr_byte_i) && state == pfta_pkg::PFTA_IDLE;
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("table write bad");

  property p_nop;
    @(posedge core_clk_i) disable iff (rst_i)
      (fetch_upd && fetch_raw == pfta_pkg::ERASED_WORD) |=> fetch_word_o == pfta_pkg::NOP_WORD;
  endproperty
  a_nop: assert property (p_nop) else $error("invalid opcode issued");

  property p_commit_busy;
    @(posedge core_clk_i) disable iff (rst_i)
      is_commit |=> busy_o && !done_o;
  endproperty
  a_commit_busy: assert property (p_commit_busy) else $error("commit did not stall");

  property p_done_pulse;
    @(posedge core_clk_i) disable iff (rst_i)
      done_o |=> !done_o && !busy_o;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");

  property p_rd_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      (rd_valid_o && !rd_ready_i) |=> rd_valid_o && $stable(rd_byte_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte moved while stalled");

  c_read: cover property (@(posedge core_clk_i) disable iff (rst_i) is_rd ##[1:4] rd_valid_o);
  c_prog: cover property (@(posedge core_clk_i) disable iff (rst_i) done_o);
  c_bulk: cover property (@(posedge core_clk_i) disable iff (rst_i) refused_o);
  c_stall: cover property (@(posedge core_clk_i) disable iff (rst_i)
    rd_valid_o && !rd_ready_i ##1 !bif.in_ready);
endmodule
`default_nettype wire

// file: verif/pfta_core_model.sv
// core-side model: issues table commands, drains read bytes, fetches words
// assumes the bench calls its tasks from one process, just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pfta_core_model (
  // clock
  input wire logic core_clk_i,
  // command toward the block
  output logic cmd_valid_o,
  output logic [2:0] cmd_o,
  output logic [11:0] addr_o,
  output logic [7:0] byte_o,
  // read stream and fetch
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_byte_i,
  output logic rd_ready_o,
  output logic [10:0] fetch_addr_o,
  input wire logic [15:0] fetch_word_i
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = 3'h0;
    addr_o = 12'h000;
    byte_o = 8'h00;
    rd_ready_o = 1'b1;
    fetch_addr_o = 11'h000;
  end
  task automatic issue(input logic [2:0] c, input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_o = c;
    addr_o = a;
    byte_o = d;
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b0;
  endtask
  // a slow sink holds ready low for st cycles; the byte must stand meanwhile
  task automatic read_byte(input logic [11:0] a, input int st, output logic [7:0] b,
      output bit ok);
    int n;
    n = 0;
    rd_ready_o = (st == 0);
    issue(pfta_pkg::PFTA_CMD_READ, a, 8'h00);
    while (rd_valid_i !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    b = rd_byte_i;
    ok = (n < 50);
    repeat (st) begin
      @(posedge core_clk_i);
      #1;
      ok = ok && (rd_valid_i === 1'b1) && (rd_byte_i === b);
    end
    rd_ready_o = 1'b1;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic fetch(input logic [10:0] a, output logic [15:0] w);
    fetch_addr_o = a;
    repeat (2) begin
      @(posedge core_clk_i);
      #1;
    end
    w = fetch_word_i;
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the table access block
// assumes short timer parameters; commit checks count cycles from the take edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  total_checks++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module tb_top;
  localparam int PC = 10;
  localparam int EC = 12;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int fail_count = 0;
  int total_checks = 0;
  wire logic cv, rv, rr, busy_o, refused_o, done_o;
  wire logic [2:0] cm;
  wire logic [11:0] ad;
  wire logic [7:0] wb, rb;
  wire logic [10:0] fa;
  wire logic [15:0] fw;
  always #5 clk = ~clk;
  pfta_core_model core (.core_clk_i(clk), .cmd_valid_o(cv), .cmd_o(cm), .addr_o(ad),
    .byte_o(wb), .rd_valid_i(rv), .rd_byte_i(rb), .rd_ready_o(rr), .fetch_addr_o(fa),
    .fetch_word_i(fw));
  pfta_top #(.PROG_CYC(PC), .ERASE_CYC(EC)) uut (.core_clk_i(clk), .rst_i(rst),
    .cmd_valid_i(cv), .cmd_i(cm), .tbl_addr_i(ad), .wr_byte_i(wb), .rd_valid_o(rv),
    .rd_byte_o(rb), .rd_ready_i(rr), .fetch_addr_i(fa), .fetch_word_o(fw),
    .busy_o(busy_o), .refused_o(refused_o), .done_o(done_o));
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input int st);
    logic [7:0] b;
    bit ok;
    core.read_byte(a, st, b, ok);
    if (!ok) begin
      fail_count++;
      summarize();
    end
    `CHK(b, e);
    `CHK(rv, 1'b0);
  endtask
  // fetch frozen and a read ignored while the timer runs
  task automatic commit(input logic [2:0] c, input logic [11:0] a, input int lim);
    int n;
    logic [15:0] w0, w1;
    core.fetch(11'h000, w0);
    core.issue(c, a, 8'h00);
    @(posedge clk);
    #1;
    `CHK(busy_o, 1'b1);
    core.fetch(11'h7ff, w1);
    `CHK(w1, w0);
    core.issue(pfta_pkg::PFTA_CMD_READ, a, 8'h00);
    n = 5;
    while (done_o !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      `CHK(rv, 1'b0);
      n++;
    end
    `CHK(n, lim);
    `CHK(busy_o, 1'b0);
    if (n >= 5000) summarize();
    @(posedge clk);
    #1;
    `CHK(done_o, 1'b0);
  endtask
  task automatic t_erase();
    for (int k = 0; k < 2; k++) begin
      commit(pfta_pkg::PFTA_CMD_ERASE, 12'(k * 1024 + 'h123), EC);
    end
    rd(12'h000, 8'hff, 0);
    rd(12'h7ff, 8'hff, 0);
  endtask
  task automatic t_bulk();
    core.issue(pfta_pkg::PFTA_CMD_BULK, 12'h000, 8'h00);
    `CHK({refused_o, busy_o}, 2'b10);
    @(posedge clk);
    #1;
    `CHK(refused_o, 1'b0);
    rd(12'h522, 8'ha5, 0);
  endtask
  task automatic t_pair();
    logic [15:0] w;
    core.issue(pfta_pkg::PFTA_CMD_WRITE, 12'h522, 8'ha5);
    core.issue(pfta_pkg::PFTA_CMD_WRITE, 12'h523, 8'h3c);
    rd(12'h523, 8'hff, 0);
    commit(pfta_pkg::PFTA_CMD_PROG_PAIR, 12'h522, PC);
    rd(12'h523, 8'h3c, 4);
    rd(12'h522, 8'ha5, 0);
    rd(12'h524, 8'hff, 0);
    core.fetch(11'h291, w);
    `CHK(w, 16'h3ca5);
    core.fetch(11'h292, w);
    `CHK(w, pfta_pkg::NOP_WORD);
  endtask
  task automatic t_block();
    for (int i = 0; i < 64; i++) begin
      core.issue(pfta_pkg::PFTA_CMD_WRITE, 12'(12'h040 + i), 8'(i) ^ 8'h5a);
    end
    commit(pfta_pkg::PFTA_CMD_PROG_BLK, 12'h07f, PC);
    rd(12'h040, 8'h5a, 0);
    rd(12'h05b, 8'h41, 0);
    rd(12'h07f, 8'h65, 0);
    rd(12'h080, 8'hff, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK({busy_o, rv, done_o, refused_o}, 4'h0);
    t_erase();
    t_pair();
    t_bulk();
    t_block();
    summarize();
  end
endmodule
`default_nettype wire
